/* verilog/gamma_ref_consts.vh */
// Purpose: shared constants for the gamma reference two-wire slave
// Assumes: 20 MHz system clock
// Notes: definitions only
`ifndef GAMMA_REF_CONSTS_VH
`define GAMMA_REF_CONSTS_VH
`define DEV_ADDR_HI 6'h3A
`define GEN_CALL_ADDR 7'h00
`define GEN_CALL_RESET 8'h06
`define HS_CODE_HI 5'h01
`define NUM_CHANNELS 20
`define CODE_WIDTH 10
`define CODE_RESET 10'h200
`define CHAN_LAST 5'h13
`define CMD_PREFIX 3'h0
`endif

/* verilog/pin_sync.v */
// Purpose: two-flop synchroniser for one asynchronous input
// Assumes: input comes from outside the clk domain
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync (
    clk,
    rst_b,
    async_in,
    sync_out
);
    parameter RESET_VAL = 1'b1;
    input wire clk;
    input wire rst_b;
    input wire async_in;
    output reg sync_out;
    reg meta_q;

    // two stages to settle metastability
    always @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* verilog/gamma_ref_two_wire_slave.v */
// Purpose: two-wire slave front end, 20 channels of double-registered codes
// Assumes: clk 20 MHz, bus clock at most 3.4 MHz, oversampled after sync
// Notes: write path only; reads are not acknowledged beyond the address
`timescale 1ns/1ps
`include "gamma_ref_consts.vh"

module gamma_ref_two_wire_slave (
    clk,
    rst_b,
    scl_in,
    sda_in,
    sda_out,
    sda_oe,
    address_select_pin,
    output_latch_pin,
    chan_out,
    hs_mode,
    gen_reset_pulse
);
    parameter NCH = `NUM_CHANNELS;
    parameter CW = `CODE_WIDTH;
    input wire clk;
    input wire rst_b;
    input wire scl_in;
    input wire sda_in;
    output wire sda_out;
    output wire sda_oe;
    input wire address_select_pin;
    input wire output_latch_pin;
    output wire [NCH*CW-1:0] chan_out;
    output reg hs_mode;
    output reg gen_reset_pulse;

    // bus idle, waiting for a start condition
    localparam ST_IDLE = 3'h0;
    // shifting the slave address byte
    localparam ST_ADDR = 3'h1;
    // own address seen, waiting for the channel select byte
    localparam ST_CMD = 3'h2;
    // waiting for the upper code bits of the selected channel
    localparam ST_MSB = 3'h3;
    // waiting for the lower code bits of the selected channel
    localparam ST_LSB = 3'h4;
    // general call address seen, waiting for its command byte
    localparam ST_GC = 3'h5;
    // transfer refused or not ours: ignore bits until start or stop
    localparam ST_SKIP = 3'h6;
    // reset byte accepted, reset fires when its acknowledge ends
    localparam ST_GCOK = 3'h7;

    wire scl_s;
    wire sda_s;
    wire lat_s;
    reg scl_q, sda_q, lat_q;
    reg [2:0] state_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg ack_q;
    reg [4:0] chan_q;
    reg [1:0] msb_q;
    reg [CW-1:0] store_q [0:NCH-1];
    reg [CW-1:0] out_q [0:NCH-1];
    reg wr_pulse_q;
    reg soft_rst_q;
    integer i;

    // bus pins and latch pin cross into clk domain
    pin_sync #(.RESET_VAL(1'b1)) u_scl (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(scl_in),
        .sync_out(scl_s)
    );
    pin_sync #(.RESET_VAL(1'b1)) u_sda (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(sda_in),
        .sync_out(sda_s)
    );
    pin_sync #(.RESET_VAL(1'b0)) u_lat (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(output_latch_pin),
        .sync_out(lat_s)
    );

    // edge and condition detection on synchronised copies
    // both lines pass the same synchroniser depth, so their relative
    // order is kept and a start or stop cannot be mistaken for a data bit
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_c = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c = scl_s & scl_q & ~sda_q & sda_s;
    wire lat_fall = lat_q & ~lat_s;

    // open drain: enable only pulls low, output value is constant zero
    // the high level always comes from the bus pull-up, never from us
    assign sda_out = 1'b0;
    assign sda_oe = ack_q;

    function is_own;
        input [6:0] a;
        input sel;
        begin
            is_own = (a == {`DEV_ADDR_HI, sel});
        end
    endfunction

    function is_hs_code;
        input [7:0] b;
        begin
            is_hs_code = (b[7:3] == `HS_CODE_HI);
        end
    endfunction

    // previous samples for edge detection
    // reset values match the idle bus level so no false edge follows reset
    always @(posedge clk) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            lat_q <= 1'b0;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            lat_q <= lat_s;
        end
    end

    // protocol engine: bits 0..7 data, bit 8 acknowledge slot
    // bit_q counts clock falls inside a byte; data is taken on the rise and
    // decoded on the eighth fall, the acknowledge is released on the ninth
    // a refused byte moves to the skip state, which only start or stop leave
    always @(posedge clk) begin
        if (!rst_b || soft_rst_q) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ack_q <= 1'b0;
            chan_q <= 5'h00;
            msb_q <= 2'h0;
            wr_pulse_q <= 1'b0;
            gen_reset_pulse <= 1'b0;
            hs_mode <= 1'b0;
        end else begin
            wr_pulse_q <= 1'b0;
            gen_reset_pulse <= 1'b0;
            if (stop_c) begin
                state_q <= ST_IDLE;
                ack_q <= 1'b0;
                hs_mode <= 1'b0;
            end else if (start_c) begin
                // repeated start keeps hs_mode; partial writes are dropped
                state_q <= ST_ADDR;
                // the clock fall that closes the start wraps this to zero,
                // so it is not counted as a data bit
                bit_q <= 4'hF;
                ack_q <= 1'b0;
            end else if (state_q != ST_IDLE && scl_rise && bit_q < 4'h8) begin
                shift_q <= {shift_q[6:0], sda_s};
            end else if (state_q != ST_IDLE && scl_fall) begin
                if (bit_q == 4'h8) begin
                    // end of acknowledge slot; an accepted reset fires only now
                    // so that the acknowledge of the reset byte is not cut short
                    ack_q <= 1'b0;
                    bit_q <= 4'h0;
                    if (state_q == ST_GCOK) begin
                        gen_reset_pulse <= 1'b1;
                        state_q <= ST_SKIP;
                    end
                end else if (bit_q == 4'h7) begin
                    bit_q <= 4'h8;
                    case (state_q)
                        ST_ADDR: begin
                            if (is_own(shift_q[7:1], address_select_pin) && !shift_q[0]) begin
                                ack_q <= 1'b1;
                                state_q <= ST_CMD;
                            end else if (is_own(shift_q[7:1], address_select_pin)) begin
                                ack_q <= 1'b1; // read: acked, no data
                                state_q <= ST_SKIP;
                            end else if (shift_q == {`GEN_CALL_ADDR, 1'b0}) begin
                                ack_q <= 1'b1;
                                state_q <= ST_GC;
                            end else if (is_hs_code(shift_q)) begin
                                hs_mode <= 1'b1; // no ack
                                state_q <= ST_SKIP;
                            end else begin
                                state_q <= ST_SKIP;
                            end
                        end
                        ST_GC: begin
                            if (shift_q == `GEN_CALL_RESET) begin
                                ack_q <= 1'b1;
                                state_q <= ST_GCOK;
                            end else begin
                                state_q <= ST_SKIP; // other bytes refused
                            end
                        end
                        ST_CMD: begin
                            if (shift_q[7:5] == `CMD_PREFIX && shift_q[4:0] <= `CHAN_LAST) begin
                                ack_q <= 1'b1;
                                chan_q <= shift_q[4:0];
                                state_q <= ST_MSB;
                            end else begin
                                state_q <= ST_SKIP;
                            end
                        end
                        ST_MSB: begin
                            ack_q <= 1'b1;
                            msb_q <= shift_q[1:0];
                            state_q <= ST_LSB;
                        end
                        ST_LSB: begin
                            // register written only after second byte
                            ack_q <= 1'b1;
                            wr_pulse_q <= 1'b1;
                            state_q <= ST_MSB;
                        end
                        ST_SKIP: state_q <= ST_SKIP;
                        default: state_q <= ST_IDLE;
                    endcase
                end else begin
                    bit_q <= bit_q + 4'h1;
                end
            end
            // auto increment after a completed channel write
            if (wr_pulse_q) begin
                chan_q <= (chan_q == `CHAN_LAST) ? 5'h00 : chan_q + 5'h01;
            end
        end
    end

    // general call reset applied one cycle later to the protocol engine and both register stages, not the synchronisers or edge samples
    // registered so the reset net never carries a combinational glitch
    always @(posedge clk) begin
        if (!rst_b) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= gen_reset_pulse;
        end
    end

    // double register per channel
    // the latch fall wins over a same-cycle write to the output stage,
    // so that write is lost from the output: the storage stage only takes it in that same cycle
    always @(posedge clk) begin
        if (!rst_b || soft_rst_q) begin
            for (i = 0; i < NCH; i = i + 1) begin
                store_q[i] <= `CODE_RESET;
                out_q[i] <= `CODE_RESET;
            end
        end else begin
            if (wr_pulse_q) begin
                store_q[chan_q] <= {msb_q, shift_q};
                if (!lat_s) begin
                    out_q[chan_q] <= {msb_q, shift_q};
                end
            end
            if (lat_fall) begin
                // all channels switch in one edge
                for (i = 0; i < NCH; i = i + 1) begin
                    out_q[i] <= store_q[i];
                end
            end
        end
    end

    // flatten output stage, channel 0 in low bits
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_out
            assign chan_out[g*CW +: CW] = out_q[g];
        end
    endgenerate
endmodule

/* tb/gamma_ref_two_wire_slave_properties.sv */
// Purpose: pin-level checks on the gamma reference slave
// Assumes: 400 ns bus clock against a 50 ns clk
// Notes: bound to every slave instance
`timescale 1ns/1ps
module gamma_ref_two_wire_slave_properties #(
    parameter NCH = 20,
    parameter CW = 10
) (
    input wire clk,
    input wire rst_b,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire address_select_pin,
    input wire output_latch_pin,
    input wire [NCH*CW-1:0] chan_out,
    input wire hs_mode,
    input wire gen_reset_pulse
);
    localparam [NCH*CW-1:0] MID = {NCH{10'h200}};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // six samples so the synchroniser cannot still carry a fall
    sequence latch_held;
        output_latch_pin [*6];
    endsequence
    chk_pull_only: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    chk_reset_mid: assert property (!$past(rst_b) |-> chan_out == MID)
        else $error("reset value wrong");
    chk_gc_clear: assert property (gen_reset_pulse |-> ##[1:2] chan_out == MID && !hs_mode)
        else $error("general reset incomplete");
    chk_latch_hold: assert property (latch_held |-> $stable(chan_out) ||
        $past(gen_reset_pulse) || $past(gen_reset_pulse, 2))
        else $error("output moved while latched");
    chk_ack_width: assert property ($rose(sda_oe) |-> sda_oe [*4])
        else $error("ack too short");
    chk_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("ack began with clock high");
    chk_hs_exit: assert property ($fell(hs_mode) |-> (scl_in && sda_in) ||
        $past(gen_reset_pulse))
        else $error("fast mode left without stop");
    chk_code_no_ack: assert property ($rose(hs_mode) |-> !sda_oe [*4])
        else $error("master code acked");
endmodule

bind gamma_ref_two_wire_slave gamma_ref_two_wire_slave_properties #(.NCH(NCH), .CW(CW)) u_chk (
    .clk(clk),
    .rst_b(rst_b),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .address_select_pin(address_select_pin),
    .output_latch_pin(output_latch_pin),
    .chan_out(chan_out),
    .hs_mode(hs_mode),
    .gen_reset_pulse(gen_reset_pulse)
);

/* tb/two_wire_master_model.sv */
// Purpose: two-wire bus master driving the slave
// Assumes: 400 ns bus clock, pull-ups on both lines
// Notes: clock stands high between frames
`timescale 1ns/1ps
module two_wire_master_model (
    output logic scl_low,
    output logic sda_low,
    input wire sda
);
    // both released at idle; lines are only ever pulled low
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // data falls while clock high, also usable as repeated start
    task automatic start_c();
        sda_low = 1'b0;
        #100 scl_low = 1'b0;
        #100 sda_low = 1'b1;
        #100 scl_low = 1'b1;
        #100;
    endtask
    // data rises while clock high
    task automatic stop_c();
        sda_low = 1'b1;
        #100 scl_low = 1'b0;
        #100 sda_low = 1'b0;
        #100;
    endtask
    // eight bits msb first, data moved only with clock low, ninth reads ack
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low = ~b[i];
            #100 scl_low = 1'b0;
            #200 scl_low = 1'b1;
            #100;
        end
        sda_low = 1'b0;
        #100 scl_low = 1'b0;
        #100 ack = ~sda;
        #100 scl_low = 1'b1;
        #100;
    endtask
endmodule

/* tb/test_gamma_ref_two_wire_slave.sv */
// Purpose: self-checking bench for the gamma reference slave
// Assumes: clk 50 ns, bus clock 400 ns from the master model
// Notes: every chan_out change is matched to the oldest queued note
`timescale 1ns/1ps
module test_gamma_ref_two_wire_slave;
    localparam [199:0] MID = {20{10'h200}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sel = 1'b0;
    logic latch = 1'b0;
    logic scl_low;
    logic sda_low;
    logic [199:0] exp_v = MID;
    logic [199:0] seen = 'x;
    logic [199:0] exp_q[$];
    logic [31:0] rnd = 32'h062DFCF8;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    wire sda_oe;
    wire sda_out;
    wire hs_mode;
    wire gen_reset_pulse;
    wire [199:0] chan_out;
    // open-drain lines with pull-ups
    wire scl = ~scl_low;
    wire sda = ~(sda_low | (sda_oe & ~sda_out));
    always #25 clk = ~clk;
    gamma_ref_two_wire_slave dut (
        .clk(clk),
        .rst_b(rst_b),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .address_select_pin(sel),
        .output_latch_pin(latch),
        .chan_out(chan_out),
        .hs_mode(hs_mode),
        .gen_reset_pulse(gen_reset_pulse)
    );
    two_wire_master_model m (.scl_low(scl_low), .sda_low(sda_low), .sda(sda));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [199:0] got, input logic [199:0] want);
        compares++;
        if (got !== want) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic wb(input logic [7:0] b, input logic ack);
        logic a;
        m.put_byte(b, a);
        check(200'(a), 200'(ack));
    endtask
    // bit 0 forced high so a new code never equals mid-scale
    task automatic put(input int ch, input logic show);
        logic [9:0] c;
        rnd = xs(rnd);
        c = rnd[9:0] | 10'h001;
        exp_v[ch*10+:10] = c;
        if (show)
            exp_q.push_back(exp_v);
        wb({6'h00, c[9:8]}, 1'b1);
        wb(c[7:0], 1'b1);
    endtask
    task automatic end_sim();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // sampled on the falling edge, away from the design's updates
    always @(negedge clk) begin
        if (chan_out !== seen) begin
            seen = chan_out;
            check(chan_out, exp_q.size() > 0 ? exp_q.pop_front() : ~chan_out);
        end
    end
    // hang guard, well above the roughly 1940 cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        exp_q.push_back(MID);
        repeat (12) @(posedge clk);
        #2 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk) #2 sel = p[0];
            m.start_c();
            wb({6'h3A, p[0], 1'b0}, 1'b1);
            m.start_c();
            wb({6'h3A, ~p[0], 1'b0}, 1'b0);
            m.start_c();
            wb({6'h3A, p[0], 1'b1}, 1'b1);
            m.stop_c();
        end
        // transparent latch: last channel then wrap to the first
        m.start_c();
        wb(8'hEA, 1'b1);
        wb(8'h13, 1'b1);
        put(19, 1'b1);
        put(0, 1'b1);
        m.stop_c();
        // latch held high: write stays hidden until the pin falls
        @(posedge clk) #2 latch = 1'b1;
        m.start_c();
        wb(8'hEA, 1'b1);
        wb(8'h05, 1'b1);
        put(5, 1'b0);
        m.stop_c();
        repeat (20) @(posedge clk);
        exp_q.push_back(exp_v);
        #2 latch = 1'b0;
        m.start_c();
        wb(8'hEA, 1'b1);
        wb(8'h14, 1'b0);
        m.start_c();
        rnd = xs(rnd);
        wb({5'h01, rnd[2:0]}, 1'b0);
        check(200'(hs_mode), 200'h1);
        m.start_c();
        wb(8'hEA, 1'b1);
        m.stop_c();
        repeat (10) @(posedge clk);
        check(200'(hs_mode), 200'h0);
        #2 m.start_c();
        wb(8'h00, 1'b1);
        wb(8'h07, 1'b0);
        m.start_c();
        wb(8'h00, 1'b1);
        exp_v = MID;
        exp_q.push_back(MID);
        wb(8'h06, 1'b1);
        m.stop_c();
        repeat (20) @(posedge clk);
        check(200'(exp_q.size()), 200'h0);
        end_sim();
    end
endmodule
